// ===== hdl/ipf_regs.svh
// Purpose: Register offsets, field positions, reset values and bus answers of the priority fields.
// Assumes: Each register takes one aligned 32-bit word on the AXI4-Lite bus.
// Notes:   Only byte lane 0 carries implemented bits.
`ifndef IPF_REGS_SVH
`define IPF_REGS_SVH

// ============================================================
// Register offsets (byte addresses)
`define IPF_OFS_CMP_CAP    32'h0000_0000
`define IPF_OFS_PAR_CMP8   32'h0000_0004

// ============================================================
// Field positions inside a register word
`define IPF_CAP6_LSB       0
`define IPF_CMP5_LSB       4
`define IPF_CMP8_LSB       0
`define IPF_PAR_LSB        4
`define IPF_IMPL_MASK      32'h0000_0077

// ============================================================
// Codes and reset values
`define IPF_FIELD_RST      3'h4
`define IPF_CODE_OFF       3'h0
`define IPF_CODE_LOW       3'h1
`define IPF_CODE_TOP       3'h7

// ============================================================
// AXI4-Lite response codes
`define IPF_RESP_OKAY      2'h0
`define IPF_RESP_SLVERR    2'h2

`endif

// ===== hdl/ipf_pkg.sv
// Purpose: Types shared by the priority field block.
// Assumes: Nothing beyond the register header.
// Notes:   Constants live in the register header; only types stand here.
package ipf_pkg;

    // ============================================================
    // Types
    typedef logic [2:0] ipf_code_t;
    typedef logic [1:0] ipf_resp_t;

    typedef enum logic [1:0] {
        IPF_SRC_CMP5,
        IPF_SRC_CAP6,
        IPF_SRC_PAR,
        IPF_SRC_CMP8
    } ipf_src_e;

endpackage

// ===== hdl/ipf_level_decode.sv
// Purpose: Turns one source's priority code into a level, an enable and a gated request.
// Assumes: The source flag comes from logic on aclk.
// Notes:   All outputs are registered, so they trail the code by one cycle.
`timescale 1ns/1ps
`include "ipf_regs.svh"

module ipf_level_decode (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire ipf_pkg::ipf_code_t code,
    input  wire logic              flag,
    output logic [2:0]             level,
    output logic                   enabled,
    output logic                   req
);

    // ============================================================
    // Decoding
    wire code_on = (code != `IPF_CODE_OFF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level   <= 3'h0;
            enabled <= 1'b0;
            req     <= 1'b0;
        end else begin
            // The code is the level itself: one is lowest, seven highest.
            level   <= code;
            enabled <= code_on;
            // A disabled source never reaches the arbiter.
            req     <= flag & code_on;
        end
    end

endmodule

// ===== hdl/ipf_axil_slave.sv
// Purpose: AXI4-Lite slave front end that turns bus transfers into single-cycle register strobes.
// Assumes: One write and one read at most under way at a time.
// Notes:   Write address and data are taken in either order; the strobe fires in the cycle the second of the two is taken.
`timescale 1ns/1ps
`include "ipf_regs.svh"

module ipf_axil_slave (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [31:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output ipf_pkg::ipf_resp_t      s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [31:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output ipf_pkg::ipf_resp_t      s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic                    wr_en,
    output logic [31:0]             wr_addr,
    output logic [31:0]             wr_data,
    output logic [3:0]              wr_strb,
    input  wire logic               wr_ok,
    output logic                    rd_en,
    output logic [31:0]             rd_addr,
    input  wire logic [31:0]        rd_data,
    input  wire logic               rd_ok
);

    // ============================================================
    // Write channel
    logic        aw_held_q;
    logic        w_held_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    wire aw_take   = s_axi_awvalid & s_axi_awready;
    wire w_take    = s_axi_wvalid & s_axi_wready;
    wire aw_full   = aw_held_q | aw_take;
    wire w_full    = w_held_q | w_take;
    wire fire      = aw_full & w_full & ~s_axi_bvalid;
    wire bvalid_d  = fire | (s_axi_bvalid & ~s_axi_bready);
    wire aw_held_d = aw_full & ~fire;
    wire w_held_d  = w_full & ~fire;

    assign wr_en   = fire;
    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

    // ============================================================
    // Read channel
    wire rvalid_d = rd_en | (s_axi_rvalid & ~s_axi_rready);

    assign rd_en   = s_axi_arvalid & s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 32'h0000_0000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `IPF_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `IPF_RESP_OKAY;
        end else begin
            aw_held_q     <= aw_held_d;
            w_held_q      <= w_held_d;
            s_axi_awready <= ~aw_held_d & ~bvalid_d;
            s_axi_wready  <= ~w_held_d & ~bvalid_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (fire) begin
                s_axi_bresp <= wr_ok ? `IPF_RESP_OKAY : `IPF_RESP_SLVERR;
            end
            if (rd_en) begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? `IPF_RESP_OKAY : `IPF_RESP_SLVERR;
            end
        end
    end

endmodule

// ===== hdl/ipf_top.sv
// Purpose: Priority fields for two compare channels, a capture channel and the parallel port.
// Assumes: Source flags come from logic on aclk; software is the only party on the bus.
// Notes:   Arbitration and vectoring sit downstream and read the level, enable and request outputs.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "ipf_regs.svh"

module ipf_top #(
    parameter int NSRC = 4
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [31:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output ipf_pkg::ipf_resp_t      s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [31:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output ipf_pkg::ipf_resp_t      s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic [NSRC-1:0]    src_flag,
    output logic [3*NSRC-1:0]       src_level,
    output logic [NSRC-1:0]         src_enabled,
    output logic [NSRC-1:0]         src_req
);

    // ============================================================
    // Address decoding

    // Returns a one-hot register select, or zero for an unmapped address; bit 0 is the first register, bit 1 the second.
    function automatic logic [1:0] ipf_sel(input logic [31:0] addr);
        logic [1:0] sel;
        sel    = 2'b00;
        sel[0] = (addr[31:2] == 30'(`IPF_OFS_CMP_CAP >> 2));
        sel[1] = (addr[31:2] == 30'(`IPF_OFS_PAR_CMP8 >> 2));
        return sel;
    endfunction

    logic        wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        rd_en;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;

    wire [1:0] wr_sel = ipf_sel(wr_addr);
    wire [1:0] rd_sel = ipf_sel(rd_addr);
    wire       wr_ok  = |wr_sel;
    wire       rd_ok  = |rd_sel;

    // Every implemented bit sits in byte lane 0, so only that strobe matters.
    wire       wr_lane0 = wr_en & wr_strb[0];
    wire       wr_a     = wr_lane0 & wr_sel[0];
    wire       wr_b     = wr_lane0 & wr_sel[1];

    // ============================================================
    // Bus front end
    ipf_axil_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // ============================================================
    // Priority field storage
    ipf_pkg::ipf_code_t cmp5_q;
    ipf_pkg::ipf_code_t cap6_q;
    ipf_pkg::ipf_code_t par_q;
    ipf_pkg::ipf_code_t cmp8_q;

    wire ipf_pkg::ipf_code_t wr_cap6 = wr_data[`IPF_CAP6_LSB +: 3];
    wire ipf_pkg::ipf_code_t wr_cmp5 = wr_data[`IPF_CMP5_LSB +: 3];
    wire ipf_pkg::ipf_code_t wr_cmp8 = wr_data[`IPF_CMP8_LSB +: 3];
    wire ipf_pkg::ipf_code_t wr_par  = wr_data[`IPF_PAR_LSB +: 3];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Mid-level default lets software raise or lower a source without a read first.
            cmp5_q <= `IPF_FIELD_RST;
            cap6_q <= `IPF_FIELD_RST;
            par_q  <= `IPF_FIELD_RST;
            cmp8_q <= `IPF_FIELD_RST;
        end else begin
            if (wr_a) begin
                cap6_q <= wr_cap6;
                cmp5_q <= wr_cmp5;
            end
            if (wr_b) begin
                cmp8_q <= wr_cmp8;
                par_q  <= wr_par;
            end
        end
    end

    // ============================================================
    // Read data
    logic [31:0] word_a;
    logic [31:0] word_b;

    always_comb begin
        word_a                          = 32'h0000_0000;
        word_a[`IPF_CAP6_LSB +: 3]      = cap6_q;
        word_a[`IPF_CMP5_LSB +: 3]      = cmp5_q;
        word_b                          = 32'h0000_0000;
        word_b[`IPF_CMP8_LSB +: 3]      = cmp8_q;
        word_b[`IPF_PAR_LSB +: 3]       = par_q;
    end

    // Bits outside the implemented mask are never stored, so they read as zero.
    assign rd_data = ((rd_sel[0] ? word_a : 32'h0000_0000)
                    | (rd_sel[1] ? word_b : 32'h0000_0000)) & `IPF_IMPL_MASK;

    // ============================================================
    // Per-source level decoding
    ipf_pkg::ipf_code_t codes [NSRC];

    assign codes[ipf_pkg::IPF_SRC_CMP5] = cmp5_q;
    assign codes[ipf_pkg::IPF_SRC_CAP6] = cap6_q;
    assign codes[ipf_pkg::IPF_SRC_PAR]  = par_q;
    assign codes[ipf_pkg::IPF_SRC_CMP8] = cmp8_q;

    for (genvar i = 0; i < NSRC; i++) begin : g_src
        ipf_level_decode u_dec (
            .aclk    (aclk),
            .aresetn (aresetn),
            .code    (codes[i]),
            .flag    (src_flag[i]),
            .level   (src_level[3*i +: 3]),
            .enabled (src_enabled[i]),
            .req     (src_req[i])
        );
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    localparam int CMP8 = 3;
    localparam int CAP6 = 1;

    sequence write_a_s;
        wr_a;
    endsequence

    sequence write_b_s;
        wr_b;
    endsequence

    sequence read_a_s;
        rd_en && rd_sel[0];
    endsequence

    sequence answer_s;
        s_axi_rvalid && !s_axi_arready;
    endsequence

    sequence read_b_s;
        rd_en && rd_sel[1];
    endsequence

    // Two steps: the field takes code zero, then the decoder drops the source a cycle later.
    sequence write_off_s;
        wr_a && wr_cap6 == `IPF_CODE_OFF;
    endsequence

    sequence bad_write_s;
        wr_en && !wr_ok;
    endsequence

    sequence bad_read_s;
        rd_en && !rd_ok;
    endsequence

    cap_write_a: assert property (write_a_s |=> cap6_q == $past(wr_cap6))
        else $error("capture six field did not take the written code");

    cmp8_write_a: assert property (write_b_s |=> cmp8_q == $past(wr_cmp8))
        else $error("compare eight field did not take the written code");

    lane_guard_a: assert property (wr_en && !wr_strb[0] |=> $stable(cap6_q) && $stable(cmp8_q))
        else $error("field changed on a write without lane 0");

    unimpl_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & ~`IPF_IMPL_MASK) == 32'h0000_0000)
        else $error("unimplemented bit read as one");

    cap_read_a: assert property (read_a_s |=> answer_s ##0 s_axi_rdata[2:0] == $past(cap6_q))
        else $error("read of first register lost the capture six field");

    reset_default_a: assert property (!$past(aresetn) |-> cmp5_q == `IPF_FIELD_RST && cap6_q == `IPF_FIELD_RST
                                      && par_q == `IPF_FIELD_RST && cmp8_q == `IPF_FIELD_RST)
        else $error("field not at default code after reset");

    top_level_a: assert property (cmp8_q == `IPF_CODE_TOP |=>
                                  src_level[3*CMP8 +: 3] == 3'h7 && src_enabled[CMP8])
        else $error("code seven did not give level seven");

    write_answer_a: assert property (wr_en |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response did not follow the strobe");

    cmp5_write_a: assert property (write_a_s |=> cmp5_q == $past(wr_cmp5))
        else $error("compare five field did not take the written code");

    par_write_a: assert property (write_b_s |=> par_q == $past(wr_par))
        else $error("parallel port field did not take the written code");

    cmp8_read_a: assert property (read_b_s |=> answer_s ##0 s_axi_rdata[2:0] == $past(cmp8_q))
        else $error("read of second register lost the compare eight field");

    cap_off_a: assert property (write_off_s |=> ##1 !src_req[CAP6] && !src_enabled[CAP6])
        else $error("capture six still enabled after code zero was written");

    upper_zero_a: assert property (answer_s |-> s_axi_rdata[15:7] == 9'h000 && !s_axi_rdata[3])
        else $error("bits 15 to 7 or bit 3 read as one");

    // Fields move only on their own strobe; a stray strobe would silently change a source's level.
    keep_first_a: assert property (!wr_a |=> $stable(cap6_q) && $stable(cmp5_q))
        else $error("first register changed without a write");

    keep_second_a: assert property (!wr_b |=> $stable(cmp8_q) && $stable(par_q))
        else $error("second register changed without a write");

    // Every strobe gets exactly one answer, a cycle later.
    read_answer_a: assert property (rd_en |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data did not follow the address");

    ok_write_a: assert property (wr_en && wr_ok |=> s_axi_bresp == `IPF_RESP_OKAY)
        else $error("mapped write did not answer OKAY");

    ok_read_a: assert property (rd_en && rd_ok |=> s_axi_rresp == `IPF_RESP_OKAY)
        else $error("mapped read did not answer OKAY");

    bad_write_a: assert property (bad_write_s |=> s_axi_bresp == `IPF_RESP_SLVERR)
        else $error("unmapped write was not refused");

    bad_read_a: assert property (bad_read_s |=> s_axi_rresp == `IPF_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read was not refused");

    for (genvar j = 0; j < NSRC; j++) begin : g_chk
        off_no_req_a: assert property (codes[j] == `IPF_CODE_OFF |=> !src_req[j] && !src_enabled[j])
            else $error("disabled source raised a request");

        low_level_a: assert property (codes[j] == `IPF_CODE_LOW |=>
                                      src_level[3*j +: 3] == 3'h1 && src_enabled[j])
            else $error("code one did not give level one");

        // The release edge still loads reset values, so these wait until reset is sampled high.
        linear_level_a: assert property (aresetn |=> src_level[3*j +: 3] == $past(codes[j]))
            else $error("level does not follow the code");

        req_pass_a: assert property (aresetn && src_flag[j] && codes[j] != `IPF_CODE_OFF |=> src_req[j])
            else $error("enabled source flag did not raise a request");

        en_match_a: assert property (aresetn |=> src_enabled[j] == ($past(codes[j]) != `IPF_CODE_OFF))
            else $error("enable does not follow the code");

        req_block_a: assert property (aresetn && !src_flag[j] |=> !src_req[j])
            else $error("request raised without a source flag");
    end

endmodule

// ===== test/tb_interrupt_priority_fields.sv
// Purpose: Self-checking bench for the priority field block over its AXI4-Lite port and source outputs.
// Assumes: Answers come within a few cycles; the bench master never assumes how many.
// Notes:   Table rows hold register words, flags and expected levels; reset, strobe and unmapped cases follow.
`timescale 1ns/1ps
`include "ipf_regs.svh"

module tb_interrupt_priority_fields;

    // ============================================================
    // Signals
    logic               aclk;
    logic               aresetn;
    logic [31:0]        s_axi_awaddr;
    logic               s_axi_awvalid;
    logic               s_axi_awready;
    logic [31:0]        s_axi_wdata;
    logic [3:0]         s_axi_wstrb;
    logic               s_axi_wvalid;
    logic               s_axi_wready;
    ipf_pkg::ipf_resp_t s_axi_bresp;
    logic               s_axi_bvalid;
    logic               s_axi_bready;
    logic [31:0]        s_axi_araddr;
    logic               s_axi_arvalid;
    logic               s_axi_arready;
    logic [31:0]        s_axi_rdata;
    ipf_pkg::ipf_resp_t s_axi_rresp;
    logic               s_axi_rvalid;
    logic               s_axi_rready;
    logic [3:0]         src_flag;
    logic [11:0]        src_level;
    logic [3:0]         src_enabled;
    logic [3:0]         src_req;
    int                 errors;
    int                 total_checks;
    logic [31:0]        rd;
    ipf_pkg::ipf_resp_t rsp;

    ipf_top #(.NSRC(4)) i_dut (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .src_flag      (src_flag),
        .src_level     (src_level),
        .src_enabled   (src_enabled),
        .src_req       (src_req)
    );

    // ============================================================
    // Clock and watchdog
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge aclk);
        errors = errors + 1;
        report_and_stop();
    end

    // ============================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    // Address and data are offered together; each is dropped at the edge that takes it.
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                             output ipf_pkg::ipf_resp_t r);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done  = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output ipf_pkg::ipf_resp_t r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Reads both words and checks the source outputs against the expected levels.
    task automatic check_all(input logic [31:0] w0, input logic [31:0] w1, input logic [3:0] f,
                             input logic [11:0] lv);
        logic [3:0] en;
        for (int i = 0; i < 4; i++) en[i] = (lv[3*i +: 3] != 3'h0);
        repeat (3) @(posedge aclk);
        axi_read(`IPF_OFS_CMP_CAP, rd, rsp);
        check(rd, w0 & `IPF_IMPL_MASK);
        check({30'h0, rsp}, {30'h0, `IPF_RESP_OKAY});
        axi_read(`IPF_OFS_PAR_CMP8, rd, rsp);
        check(rd, w1 & `IPF_IMPL_MASK);
        check({20'h0, src_level}, {20'h0, lv});
        check({28'h0, src_enabled}, {28'h0, en});
        check({28'h0, src_req}, {28'h0, f & en});
    endtask

    // ============================================================
    // Table of ordinary cases
    logic [31:0] row_w0 [6] = '{32'h0000_0070, 32'h0000_0017, 32'h0000_0000,
                                32'h0000_0035, 32'h0000_0077, 32'hffff_ff88};
    logic [31:0] row_w1 [6] = '{32'h0000_0001, 32'h0000_0070, 32'h0000_0000,
                                32'h0000_0026, 32'h0000_0077, 32'h0000_ff8b};
    logic [3:0]  row_f  [6] = '{4'hf, 4'hf, 4'hf, 4'h5, 4'ha, 4'hf};
    logic [11:0] row_lv [6] = '{12'h207, 12'h1f9, 12'h000, 12'hcab, 12'hfff, 12'h600};

    // ============================================================
    // Main sequence
    initial begin
        errors        = 0;
        total_checks  = 0;
        aresetn       = 1'b0;
        s_axi_awaddr  = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 32'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        src_flag      = 4'h0;
        do_reset();
        check_all(32'h0000_0044, 32'h0000_0044, 4'h0, 12'h924);
        $display("test reset_values done");

        for (int i = 0; i < 6; i++) begin
            axi_write(`IPF_OFS_CMP_CAP, row_w0[i], 4'hf, rsp);
            check({30'h0, rsp}, {30'h0, `IPF_RESP_OKAY});
            axi_write(`IPF_OFS_PAR_CMP8, row_w1[i], 4'hf, rsp);
            check({30'h0, rsp}, {30'h0, `IPF_RESP_OKAY});
            @(posedge aclk);
            src_flag <= row_f[i];
            check_all(row_w0[i], row_w1[i], row_f[i], row_lv[i]);
        end
        $display("test code_table done");

        // Lane 0 strobe low leaves the fields alone but still answers OKAY.
        axi_write(`IPF_OFS_CMP_CAP, 32'h0000_0011, 4'he, rsp);
        check({30'h0, rsp}, {30'h0, `IPF_RESP_OKAY});
        check_all(32'h0000_0000, 32'h0000_0003, 4'hf, 12'h600);
        $display("test strobe_off done");

        axi_write(32'h0000_0008, 32'h0000_0077, 4'hf, rsp);
        check({30'h0, rsp}, {30'h0, `IPF_RESP_SLVERR});
        axi_read(32'h0000_0008, rd, rsp);
        check(rd, 32'h0);
        check({30'h0, rsp}, {30'h0, `IPF_RESP_SLVERR});
        check_all(32'h0000_0000, 32'h0000_0003, 4'hf, 12'h600);
        $display("test unmapped done");

        // A second reset in mid-run must bring every field back to its default.
        axi_write(`IPF_OFS_PAR_CMP8, 32'h0000_0012, 4'hf, rsp);
        do_reset();
        check_all(32'h0000_0044, 32'h0000_0044, 4'hf, 12'h924);
        $display("test second_reset done");
        report_and_stop();
    end

endmodule
